// ---- hdl/tsp_pkg.sv ----
// shared constants and types for the table search and pointer move engine
package tsp_pkg;

  localparam int WORD_W = 16;
  localparam int MEM_AW = 8;
  localparam int MEM_DEPTH = 256;

  typedef logic [WORD_W-1:0] tsp_word_t;

  typedef enum logic {
    OP_FIND_GT = 1'b0,
    OP_TABLE_TO_DEST = 1'b1
  } tsp_op_e;

  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] FIND_MAX_LEN = 16'h00FF;
  localparam logic [15:0] MOVE_LEN_MASK = 16'h00FF;
  localparam logic [15:0] PTR_START = 16'h0000;
  localparam logic [15:0] PTR_WRAP = 16'h0001;
  localparam logic [15:0] NOT_FOUND_ACC = 16'h0000;
  localparam logic [15:0] DATA_OFS = 16'h0001;
  localparam logic [15:0] STEP_ONE = 16'h0001;

  // unsigned word compare
  function automatic logic tsp_gt(input tsp_word_t a, input tsp_word_t b);
    return a > b;
  endfunction

  // word addition that wraps in 16 bits
  function automatic tsp_word_t tsp_add(input tsp_word_t a, input tsp_word_t b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0];
  endfunction

endpackage

// ---- hdl/tsp_link_if.sv ----
// link between the ladder executor and the table engine
`timescale 1ns/1ns
interface tsp_link_if;
  import tsp_pkg::*;
  // operation request
  logic op_req;
  tsp_op_e op_code;
  tsp_word_t acc;
  tsp_word_t stack1;
  tsp_word_t operand;
  logic scan_end;
  // operation answer
  logic op_done;
  logic acc_load;
  tsp_word_t res_acc;
  logic not_found_flag;
  logic table_end_flag;
  // data memory access
  logic mem_req;
  logic mem_we;
  tsp_word_t mem_addr;
  tsp_word_t mem_wdata;
  tsp_word_t mem_rdata;
  logic mem_ack;

  modport engine (
    input op_req, op_code, acc, stack1, operand, scan_end, mem_rdata, mem_ack,
    output op_done, acc_load, res_acc, not_found_flag, table_end_flag,
    output mem_req, mem_we, mem_addr, mem_wdata
  );

  modport executor (
    output op_req, op_code, acc, stack1, operand, scan_end, mem_rdata, mem_ack,
    input op_done, acc_load, res_acc, not_found_flag, table_end_flag,
    input mem_req, mem_we, mem_addr, mem_wdata
  );
endinterface

// ---- hdl/tsp_engine.sv ----
// table engine: greater-than search and table-to-destination move
//
// How it works
// - search finds first entry above operand
// - executor loads length and start first
// - search always starts at offset zero
// - search length 16-bit, table max 255
// - match offset returned in accumulator
// - no match: not-found flag, accumulator zero
// - result starts at zero, flag per op
// - move one word, pointer plus one
// - start word holds pointer, data follows
// - move runs once each enabled scan; with one-shot, only on the scan where enable rises
// - move length at most FF, destination operand
// - pointer wraps to one, never zero
// - move flags last until op or scan end
// - end-of-table flag cleared at scan end
// - executor uses one-shot and first-scan init
// - end flag when pointer equals length
`timescale 1ns/1ns
module tsp_engine
  import tsp_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // executor link
  tsp_link_if.engine lnk,
  // status
  output logic busy
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FG_RD = 3'b001,
    ST_TT_PTR = 3'b011,
    ST_TT_RD = 3'b010,
    ST_TT_WDST = 3'b110,
    ST_TT_WPTR = 3'b111,
    ST_DONE = 3'b101
  } tsp_state_e;

  tsp_state_e state_r;
  tsp_op_e op_r;
  tsp_word_t start_r;
  tsp_word_t len_r;
  tsp_word_t opnd_r;
  tsp_word_t idx_r;
  tsp_word_t ptr_r;
  tsp_word_t data_r;
  logic found_r;
  logic mem_req_r;
  logic mem_we_r;
  tsp_word_t mem_addr_r;
  tsp_word_t mem_wdata_r;
  logic op_done_r;
  logic acc_load_r;
  tsp_word_t res_acc_r;
  logic not_found_r;
  logic table_end_r;
  logic busy_r;

  tsp_word_t find_len;
  tsp_word_t ptr_nxt;
  tsp_word_t data_addr;
  tsp_word_t idx_nxt;
  logic mem_state;

  // a length above the table limit is cut to the limit
  assign find_len = (lnk.stack1 > FIND_MAX_LEN) ? FIND_MAX_LEN : lnk.stack1;
  // a pointer at or past the length restarts at one
  assign ptr_nxt = (ptr_r >= len_r) ? PTR_WRAP : tsp_add(ptr_r, STEP_ONE);
  // pointer zero and pointer equal to length both pick the first data word
  assign data_addr = (ptr_r >= len_r) ? tsp_add(start_r, DATA_OFS)
                                      : tsp_add(tsp_add(start_r, DATA_OFS), ptr_r);
  assign idx_nxt = tsp_add(idx_r, STEP_ONE);
  assign mem_state = (state_r == ST_FG_RD) || (state_r == ST_TT_PTR) ||
                     (state_r == ST_TT_RD) || (state_r == ST_TT_WDST) ||
                     (state_r == ST_TT_WPTR);

  // sequencing and operand capture
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      op_r <= OP_FIND_GT;
      start_r <= WORD_RST;
      len_r <= WORD_RST;
      opnd_r <= WORD_RST;
      idx_r <= WORD_RST;
      ptr_r <= WORD_RST;
      data_r <= WORD_RST;
      found_r <= 1'b0;
    end else if (ce) begin
      case (state_r)
        ST_IDLE: begin
          if (lnk.op_req) begin
            op_r <= lnk.op_code;
            start_r <= lnk.acc;
            opnd_r <= lnk.operand;
            idx_r <= PTR_START;
            found_r <= 1'b0;
            if (lnk.op_code == OP_FIND_GT) begin
              len_r <= find_len;
              state_r <= (find_len == WORD_RST) ? ST_DONE : ST_FG_RD;
            end else begin
              len_r <= lnk.stack1 & MOVE_LEN_MASK;
              state_r <= ST_TT_PTR;
            end
          end
        end
        ST_FG_RD: begin
          if (lnk.mem_ack) begin
            if (tsp_gt(lnk.mem_rdata, opnd_r)) begin
              found_r <= 1'b1;
              state_r <= ST_DONE;
            end else if (idx_nxt >= len_r) begin
              state_r <= ST_DONE;
            end else begin
              idx_r <= idx_nxt;
            end
          end
        end
        ST_TT_PTR: begin
          if (lnk.mem_ack) begin
            ptr_r <= lnk.mem_rdata;
            state_r <= ST_TT_RD;
          end
        end
        ST_TT_RD: begin
          if (lnk.mem_ack) begin
            data_r <= lnk.mem_rdata;
            state_r <= ST_TT_WDST;
          end
        end
        ST_TT_WDST: begin
          if (lnk.mem_ack) begin
            state_r <= ST_TT_WPTR;
          end
        end
        ST_TT_WPTR: begin
          if (lnk.mem_ack) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // memory request: held until acknowledged, one idle cycle between accesses
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= WORD_RST;
      mem_wdata_r <= WORD_RST;
    end else if (ce) begin
      if (mem_req_r) begin
        if (lnk.mem_ack) begin
          mem_req_r <= 1'b0;
          mem_we_r <= 1'b0;
        end
      end else if (mem_state) begin
        mem_req_r <= 1'b1;
        case (state_r)
          ST_FG_RD: begin
            mem_we_r <= 1'b0;
            mem_addr_r <= tsp_add(start_r, idx_r);
          end
          ST_TT_PTR: begin
            mem_we_r <= 1'b0;
            mem_addr_r <= start_r;
          end
          ST_TT_RD: begin
            mem_we_r <= 1'b0;
            mem_addr_r <= data_addr;
          end
          ST_TT_WDST: begin
            mem_we_r <= 1'b1;
            mem_addr_r <= opnd_r;
            mem_wdata_r <= data_r;
          end
          default: begin
            mem_we_r <= 1'b1;
            mem_addr_r <= start_r;
            mem_wdata_r <= ptr_nxt;
          end
        endcase
      end
    end
  end

  // answer to the executor
  always_ff @(posedge clk) begin
    if (rst) begin
      op_done_r <= 1'b0;
      acc_load_r <= 1'b0;
      res_acc_r <= WORD_RST;
      busy_r <= 1'b0;
    end else if (ce) begin
      op_done_r <= (state_r == ST_DONE);
      acc_load_r <= (state_r == ST_DONE) && (op_r == OP_FIND_GT);
      if (state_r == ST_DONE && op_r == OP_FIND_GT) begin
        res_acc_r <= found_r ? idx_r : NOT_FOUND_ACC;
      end
      if (state_r == ST_IDLE && lnk.op_req) begin
        busy_r <= 1'b1;
      end else if (state_r == ST_DONE) begin
        busy_r <= 1'b0;
      end
    end
  end

  // not-found flag: rewritten only by the next search
  always_ff @(posedge clk) begin
    if (rst) begin
      not_found_r <= 1'b0;
    end else if (ce) begin
      if (state_r == ST_DONE && op_r == OP_FIND_GT) begin
        not_found_r <= !found_r;
      end
    end
  end

  // end-of-table flag: a setting move beats a scan-end clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      table_end_r <= 1'b0;
    end else if (ce) begin
      if (state_r == ST_DONE && op_r == OP_TABLE_TO_DEST) begin
        table_end_r <= (ptr_nxt == len_r);
      end else if (lnk.scan_end) begin
        table_end_r <= 1'b0;
      end
    end
  end

  assign lnk.mem_req = mem_req_r;
  assign lnk.mem_we = mem_we_r;
  assign lnk.mem_addr = mem_addr_r;
  assign lnk.mem_wdata = mem_wdata_r;
  assign lnk.op_done = op_done_r;
  assign lnk.acc_load = acc_load_r;
  assign lnk.res_acc = res_acc_r;
  assign lnk.not_found_flag = not_found_r;
  assign lnk.table_end_flag = table_end_r;
  assign busy = busy_r;

endmodule

// ---- hdl/tsp_executor.sv ----
// ladder executor end: parameter loading, scan pacing and word data memory
`timescale 1ns/1ns
module tsp_executor
  import tsp_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // engine link
  tsp_link_if.executor lnk,
  // scan pacing
  input wire logic scan_tick,
  // greater-than search request
  input wire logic find_start,
  input wire logic find_imm,
  input wire tsp_word_t find_value,
  input wire tsp_word_t find_len,
  input wire tsp_word_t find_base,
  // table move control
  input wire logic move_enable,
  input wire logic move_one_shot,
  input wire logic move_ptr_init,
  input wire tsp_word_t move_len,
  input wire tsp_word_t move_base,
  input wire tsp_word_t move_dest,
  // memory loader
  input wire logic ld_we,
  input wire tsp_word_t ld_addr,
  input wire tsp_word_t ld_data,
  input wire tsp_word_t rd_addr,
  output tsp_word_t rd_data,
  // results
  output tsp_word_t acc,
  output logic not_found_flag,
  output logic table_end_flag,
  output logic busy
);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LD_LEN = 3'b001,
    H_LD_ADR = 3'b011,
    H_RD_OPND = 3'b010,
    H_ISSUE = 3'b110,
    H_WAIT = 3'b111
  } tsp_hstate_e;

  tsp_word_t mem [MEM_DEPTH];
  tsp_hstate_e hst_r;
  logic cur_find_r;
  logic pend_find_r;
  logic pend_move_r;
  logic move_en_prev_r;
  logic first_scan_relay_r;
  logic op_req_r;
  logic scan_end_r;
  tsp_word_t acc_r;
  tsp_word_t stack_r;
  tsp_word_t opnd_r;
  logic mem_ack_r;
  tsp_word_t mem_rdata_r;
  tsp_word_t rd_data_r;
  logic nf_r;
  logic te_r;
  logic busy_r;
  logic rising_one_shot;
  logic move_go;
  logic dev_wr;

  assign rising_one_shot = move_enable && !move_en_prev_r;
  assign move_go = move_one_shot ? rising_one_shot : move_enable;
  assign dev_wr = lnk.mem_req && lnk.mem_we && !mem_ack_r;

  // enable edge is judged scan to scan, not cycle to cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      move_en_prev_r <= 1'b0;
      first_scan_relay_r <= 1'b1;
      scan_end_r <= 1'b0;
    end else if (ce) begin
      scan_end_r <= scan_tick;
      if (scan_tick) begin
        move_en_prev_r <= move_enable;
        first_scan_relay_r <= 1'b0;
      end
    end
  end

  // pending work; a new request beats the clear of a launched one
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_find_r <= 1'b0;
      pend_move_r <= 1'b0;
    end else if (ce) begin
      if (find_start) begin
        pend_find_r <= 1'b1;
      end else if (hst_r == H_IDLE && pend_find_r) begin
        pend_find_r <= 1'b0;
      end
      if (scan_tick && move_go) begin
        pend_move_r <= 1'b1;
      end else if (hst_r == H_IDLE && !pend_find_r && pend_move_r) begin
        pend_move_r <= 1'b0;
      end
    end
  end

  // parameter loading and issue
  always_ff @(posedge clk) begin
    if (rst) begin
      hst_r <= H_IDLE;
      cur_find_r <= 1'b0;
      op_req_r <= 1'b0;
      acc_r <= WORD_RST;
      stack_r <= WORD_RST;
      opnd_r <= WORD_RST;
      busy_r <= 1'b0;
    end else if (ce) begin
      op_req_r <= 1'b0;
      case (hst_r)
        H_IDLE: begin
          if (pend_find_r || pend_move_r) begin
            cur_find_r <= pend_find_r;
            busy_r <= 1'b1;
            hst_r <= H_LD_LEN;
          end
        end
        H_LD_LEN: begin
          stack_r <= cur_find_r ? find_len : (move_len & MOVE_LEN_MASK);
          hst_r <= H_LD_ADR;
        end
        H_LD_ADR: begin
          acc_r <= cur_find_r ? find_base : move_base;
          opnd_r <= cur_find_r ? find_value : move_dest;
          hst_r <= (cur_find_r && !find_imm) ? H_RD_OPND : H_ISSUE;
        end
        H_RD_OPND: begin
          opnd_r <= mem[find_value[MEM_AW-1:0]];
          hst_r <= H_ISSUE;
        end
        H_ISSUE: begin
          op_req_r <= 1'b1;
          hst_r <= H_WAIT;
        end
        H_WAIT: begin
          if (lnk.acc_load) begin
            acc_r <= lnk.res_acc;
          end
          if (lnk.op_done) begin
            busy_r <= 1'b0;
            hst_r <= H_IDLE;
          end
        end
        default: begin
          hst_r <= H_IDLE;
        end
      endcase
    end
  end

  // word memory; engine writes first, then loader, then first-scan pointer clear
  always_ff @(posedge clk) begin
    if (ce) begin
      if (dev_wr) begin
        mem[lnk.mem_addr[MEM_AW-1:0]] <= lnk.mem_wdata;
      end else if (ld_we) begin
        mem[ld_addr[MEM_AW-1:0]] <= ld_data;
      end else if (first_scan_relay_r && move_ptr_init) begin
        mem[move_base[MEM_AW-1:0]] <= PTR_START;
      end
    end
  end

  // one acknowledge per request, read data alongside
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_ack_r <= 1'b0;
      mem_rdata_r <= WORD_RST;
      rd_data_r <= WORD_RST;
      nf_r <= 1'b0;
      te_r <= 1'b0;
    end else if (ce) begin
      mem_ack_r <= lnk.mem_req && !mem_ack_r;
      if (lnk.mem_req && !mem_ack_r) begin
        mem_rdata_r <= mem[lnk.mem_addr[MEM_AW-1:0]];
      end
      rd_data_r <= mem[rd_addr[MEM_AW-1:0]];
      nf_r <= lnk.not_found_flag;
      te_r <= lnk.table_end_flag;
    end
  end

  assign lnk.op_req = op_req_r;
  assign lnk.op_code = cur_find_r ? OP_FIND_GT : OP_TABLE_TO_DEST;
  assign lnk.acc = acc_r;
  assign lnk.stack1 = stack_r;
  assign lnk.operand = opnd_r;
  assign lnk.scan_end = scan_end_r;
  assign lnk.mem_ack = mem_ack_r;
  assign lnk.mem_rdata = mem_rdata_r;
  assign rd_data = rd_data_r;
  assign acc = acc_r;
  assign not_found_flag = nf_r;
  assign table_end_flag = te_r;
  assign busy = busy_r;

endmodule

// ---- test/tsp_link_assertions.sv ----
// assertions on the link between executor and table engine
`timescale 1ns/1ns
module tsp_link_assertions
  import tsp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // operation request
  input wire logic op_req,
  input wire tsp_op_e op_code,
  input wire tsp_word_t acc,
  input wire tsp_word_t stack1,
  input wire logic scan_end,
  // operation answer
  input wire logic op_done,
  input wire logic acc_load,
  input wire tsp_word_t res_acc,
  input wire logic not_found_flag,
  input wire logic table_end_flag,
  // memory access
  input wire logic mem_req,
  input wire logic mem_we,
  input wire tsp_word_t mem_addr,
  input wire tsp_word_t mem_wdata,
  input wire logic mem_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_load_on_search: assert property (
    acc_load |-> op_done && op_code == OP_FIND_GT) else $error("result load outside search");
  a_first_read_base: assert property (
    op_req && (op_code == OP_TABLE_TO_DEST || stack1 != 16'h0000)
    |-> ##[1:4] (mem_req && !mem_we && mem_addr == acc)) else $error("first read not at start");
  a_empty_search: assert property (
    op_req && op_code == OP_FIND_GT && stack1 == 16'h0000
    |-> ##[1:3] (acc_load && not_found_flag)) else $error("empty search not refused");
  a_miss_zero_acc: assert property (
    acc_load && not_found_flag |-> res_acc == NOT_FOUND_ACC) else $error("miss without zero");
  a_hit_in_range: assert property (
    acc_load && !not_found_flag |-> res_acc < stack1 && res_acc < FIND_MAX_LEN)
    else $error("hit offset outside table");
  a_flag_by_search: assert property (
    !$stable(not_found_flag) |-> acc_load) else $error("search flag changed by other op");
  a_end_by_move: assert property (
    $rose(table_end_flag) |-> (op_done || $past(op_done)) && op_code == OP_TABLE_TO_DEST)
    else $error("end flag without move");
  a_end_scan_clear: assert property (
    scan_end |=> !table_end_flag || op_done || $past(op_done)) else $error("end flag kept");
  a_end_flag_hold: assert property (
    table_end_flag && !scan_end |=> table_end_flag || op_done) else $error("end flag lost");
  a_ptr_never_zero: assert property (
    mem_req && mem_we && mem_addr == acc && op_code == OP_TABLE_TO_DEST
    |-> mem_wdata != WORD_RST && (mem_wdata <= (stack1 & MOVE_LEN_MASK) || mem_wdata == PTR_WRAP))
    else $error("bad pointer write");
  a_mem_req_held: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
    else $error("memory request changed before ack");
endmodule

// ---- test/test_table_search_and_pointer_move.sv ----
// self-checking bench: executor and engine joined over the link
`timescale 1ns/1ns
module test_table_search_and_pointer_move;
  import tsp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scan_tick = 1'b0;
  logic find_start = 1'b0;
  logic find_imm = 1'b1;
  logic move_enable = 1'b0;
  logic move_one_shot = 1'b0;
  logic move_ptr_init = 1'b1;
  logic ld_we = 1'b0;
  tsp_word_t find_value = 16'h0000;
  tsp_word_t find_len = 16'h0000;
  tsp_word_t find_base = 16'h0010;
  tsp_word_t move_len = 16'h0003;
  tsp_word_t move_base = 16'h0040;
  tsp_word_t move_dest = 16'h0050;
  tsp_word_t ld_addr = 16'h0000;
  tsp_word_t ld_data = 16'h0000;
  tsp_word_t rd_addr = 16'h0000;
  tsp_word_t rd_data;
  tsp_word_t acc;
  logic nf;
  logic te;
  logic busy;
  logic eng_busy;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int p;
  tsp_word_t tbl [4] = '{16'h0005, 16'h0009, 16'h0003, 16'h8000};
  tsp_word_t mv [3] = '{16'h00A1, 16'h00A2, 16'h00A3};

  tsp_link_if lnk();
  tsp_engine u_tsp_engine(.clk(clk), .rst(rst), .ce(1'b1), .lnk(lnk.engine), .busy(eng_busy));
  tsp_executor u_tsp_executor(.clk(clk), .rst(rst), .ce(1'b1), .lnk(lnk.executor),
    .scan_tick(scan_tick), .find_start(find_start), .find_imm(find_imm),
    .find_value(find_value), .find_len(find_len), .find_base(find_base),
    .move_enable(move_enable), .move_one_shot(move_one_shot), .move_ptr_init(move_ptr_init),
    .move_len(move_len), .move_base(move_base), .move_dest(move_dest),
    .ld_we(ld_we), .ld_addr(ld_addr), .ld_data(ld_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .acc(acc), .not_found_flag(nf), .table_end_flag(te), .busy(busy));
  tsp_link_assertions u_tsp_link_assertions(.clk(clk), .rst(rst), .op_req(lnk.op_req),
    .op_code(lnk.op_code), .acc(lnk.acc), .stack1(lnk.stack1), .scan_end(lnk.scan_end),
    .op_done(lnk.op_done), .acc_load(lnk.acc_load), .res_acc(lnk.res_acc),
    .not_found_flag(lnk.not_found_flag), .table_end_flag(lnk.table_end_flag),
    .mem_req(lnk.mem_req), .mem_we(lnk.mem_we), .mem_addr(lnk.mem_addr),
    .mem_wdata(lnk.mem_wdata), .mem_ack(lnk.mem_ack));

  always #50 clk = ~clk;

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic chk(input string what, input tsp_word_t seen, input tsp_word_t exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic settle();
    repeat (3) @(negedge clk);
    for (int i = 0; i < 400 && (busy | eng_busy) !== 1'b0; i++) begin
      @(negedge clk);
    end
    // flags reach the executor outputs a cycle late
    repeat (2) @(negedge clk);
  endtask

  task automatic wr(input tsp_word_t a, input tsp_word_t d);
    @(negedge clk);
    ld_we = 1'b1;
    ld_addr = a;
    ld_data = d;
    @(negedge clk);
    ld_we = 1'b0;
  endtask

  task automatic rd(input tsp_word_t a, input tsp_word_t exp, input string what);
    @(negedge clk);
    rd_addr = a;
    repeat (2) @(negedge clk);
    chk(what, rd_data, exp);
  endtask

  task automatic find(input tsp_word_t v, input logic imm, input tsp_word_t len,
                      input tsp_word_t ea, input tsp_word_t enf);
    @(negedge clk);
    find_value = v;
    find_imm = imm;
    find_len = len;
    find_start = 1'b1;
    @(negedge clk);
    find_start = 1'b0;
    settle();
    chk("acc", acc, ea);
    chk("not_found", {15'h0000, nf}, enf);
  endtask

  task automatic scan();
    @(negedge clk);
    scan_tick = 1'b1;
    @(negedge clk);
    scan_tick = 1'b0;
    settle();
  endtask

  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 3; i++) begin
      wr(16'h0010 + 16'(i), tbl[i]);
      wr(16'h0041 + 16'(i), mv[i]);
    end
    wr(16'h0013, tbl[3]);
    wr(16'h0020, 16'h7FFF);
    find(16'h0006, 1'b1, 16'h0004, 16'h0001, 16'h0000);
    find(16'h0004, 1'b1, 16'h0004, 16'h0000, 16'h0000);
    find(16'h0009, 1'b1, 16'h0004, 16'h0003, 16'h0000);
    find(16'h0020, 1'b0, 16'h0004, 16'h0003, 16'h0000);
    find(16'h0009, 1'b1, 16'h0002, 16'h0000, 16'h0001);
    find(16'h0002, 1'b1, 16'h0000, 16'h0000, 16'h0001);
    // first scan ends here, pointer init stops with it
    scan();
    move_ptr_init = 1'b0;
    rd(move_base, 16'h0000, "pointer");
    move_enable = 1'b1;
    p = 0;
    for (int s = 0; s < 6; s++) begin
      scan();
      rd(move_dest, mv[(p >= 3) ? 0 : p], "dest");
      p = (p >= 3) ? 1 : p + 1;
      rd(move_base, 16'(p), "pointer");
      chk("table_end", {15'h0000, te}, 16'(p == 3));
    end
    move_enable = 1'b0;
    scan();
    chk("table_end", {15'h0000, te}, 16'h0000);
    rd(move_base, 16'h0003, "pointer");
    chk("not_found", {15'h0000, nf}, 16'h0001);
    move_one_shot = 1'b1;
    move_enable = 1'b1;
    scan();
    rd(move_dest, 16'h00A1, "dest");
    scan();
    rd(move_base, 16'h0001, "pointer");
    finish_test();
  end
endmodule
